// ==== ipr_bus_slave.sv ====
// avalon-mm waitrequest handshake for the priority register bank
`timescale 1ns/10ps
module ipr_bus_slave
   import ipr_pkg::*;
(
   input  wire logic ref_clk_in,
   input  wire logic nrst_in,
   input  wire logic read_in,
   input  wire logic write_in,
   output logic      waitrequest_out,
   output logic      capture_out,
   output logic      commit_out
);

   ipr_bus_state_t state_reg;
   ipr_bus_state_t state_next;
   logic           wait_reg;

   // a request is captured in idle and answered one cycle later
   assign capture_out = (state_reg == IPR_BUS_IDLE) && (read_in || write_in);
   // the edge that sees waitrequest low is the one that commits
   assign commit_out  = (state_reg == IPR_BUS_ACK);

   // next state
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         IPR_BUS_IDLE: begin
            if (read_in || write_in) begin
               state_next = IPR_BUS_ACK;
            end
         end
         IPR_BUS_ACK: begin
            state_next = IPR_BUS_IDLE;
         end
      endcase
   end

   // state register
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state_reg <= IPR_BUS_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // waitrequest stays high except in the single answer cycle
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         wait_reg <= 1'b1;
      end else begin
         wait_reg <= (state_next != IPR_BUS_ACK);
      end
   end

   assign waitrequest_out = wait_reg;

endmodule

// ==== ipr_field_reg.sv ====
// one source's priority and subpriority field register
`timescale 1ns/10ps
module ipr_field_reg
   import ipr_pkg::*;
(
   input  wire logic                  ref_clk_in,
   input  wire logic                  nrst_in,
   input  wire logic                  write_in,
   input  wire logic [IPR_LANE_W-1:0] lane_in,
   output ipr_src_field_t             field_out
);

   ipr_src_field_t field_reg;

   // reserved upper bits of the lane are simply not stored
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         field_reg.prio <= IPR_PRIO_OFF;
         field_reg.sub  <= IPR_SUB_RST;
      end else if (write_in) begin
         field_reg.prio <= lane_in[IPR_PRIO_LSB +: IPR_PRIO_W];
         field_reg.sub  <= lane_in[IPR_SUB_LSB +: IPR_SUB_W];
      end
   end

   assign field_out = field_reg;

endmodule

// ==== ipr_pkg.sv ====
// constants, types and the register map of the priority register bank
package ipr_pkg;

   // bus geometry
   localparam int IPR_ADDR_W = 4;
   localparam int IPR_DATA_W = 32;
   localparam int IPR_BE_W   = 4;
   localparam int IPR_LANE_W = 8;

   // register byte offsets
   localparam logic [IPR_ADDR_W-1:0] IPR_OFS_CTL4 = 4'h0;
   localparam logic [IPR_ADDR_W-1:0] IPR_OFS_CTL5 = 4'h4;
   localparam logic [IPR_ADDR_W-1:0] IPR_OFS_STAT = 4'h8;

   // field layout inside one byte lane
   localparam int IPR_PRIO_W   = 3;
   localparam int IPR_SUB_W    = 2;
   localparam int IPR_PRIO_LSB = 2;
   localparam int IPR_SUB_LSB  = 0;
   localparam logic [IPR_LANE_W-1:0] IPR_RSVD_MASK = 8'he0;
   localparam logic [IPR_PRIO_W-1:0] IPR_PRIO_OFF  = 3'h0;
   localparam logic [IPR_SUB_W-1:0]  IPR_SUB_RST   = 2'h0;

   // sources: 0 timer4, 1 capture4, 2 timer5, 3 capture5, 4 compare5, 5 serial1
   localparam int IPR_NUM_SRC     = 6;
   localparam int IPR_SRC_TIMER4  = 0;
   localparam int IPR_SRC_CAPT4   = 1;
   localparam int IPR_SRC_TIMER5  = 2;
   localparam int IPR_SRC_CAPT5   = 3;
   localparam int IPR_SRC_CMP5    = 4;
   localparam int IPR_SRC_SERIAL1 = 5;
   // register holding each source: 1 = ctl_5, 0 = ctl_4
   localparam logic [IPR_NUM_SRC-1:0]   IPR_SRC_IN_CTL5 = 6'h3c;
   // byte lane of each source, two bits per source, source 0 lowest
   localparam logic [2*IPR_NUM_SRC-1:0] IPR_SRC_LANE    = 12'he44;

   // status register layout
   localparam int IPR_STAT_EN_LSB   = 0;
   localparam int IPR_STAT_PEND_LSB = 8;
   localparam int IPR_STAT_RSVD_BIT = 16;
   localparam int IPR_STAT_RSVD_BE  = 2;

   // avalon response codes
   localparam logic [1:0] IPR_RESP_OKAY   = 2'h0;
   localparam logic [1:0] IPR_RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [IPR_PRIO_W-1:0] prio;
      logic [IPR_SUB_W-1:0]  sub;
   } ipr_src_field_t;

   typedef struct packed {
      logic                  read;
      logic                  write;
      logic [IPR_ADDR_W-1:0] addr;
      logic [IPR_BE_W-1:0]   be;
      logic [IPR_DATA_W-1:0] wdata;
   } ipr_avl_req_t;

   typedef enum logic [0:0] {
      IPR_BUS_IDLE = 1'b0,
      IPR_BUS_ACK  = 1'b1
   } ipr_bus_state_t;

endpackage

// ==== ipr_prio_bank.sv ====
// priority register bank for timer4, capture4, serial1, compare5, capture5, timer5
//
// Added by the designer: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/10ps

// Function
// - capture4 priority lives in ctl_4 bits 12..10, codes 7..1 are levels
// - a priority of zero disables the source; no request is ever raised
// - capture4 subpriority lives in ctl_4 bits 9..8, value gives level
// - timer4 priority lives in ctl_4 bits 4..2, zero means disabled
// - timer4 subpriority lives in ctl_4 bits 1..0, value gives level
// - serial1 priority lives in ctl_5 bits 28..26, bits 31..29 reserved
// - serial1 subpriority lives in ctl_5 bits 25..24
// - each ctl_5 byte: three reserved bits, priority, subpriority; sources top down
// - all priority and subpriority bits are read/write and reset to zero
module ipr_prio_bank
   import ipr_pkg::*;
(
   input  wire logic                                   ref_clk_in,
   input  wire logic                                   nrst_in,
   input  wire logic [IPR_ADDR_W-1:0]                  avs_address_in,
   input  wire logic                                   avs_read_in,
   input  wire logic                                   avs_write_in,
   input  wire logic [IPR_BE_W-1:0]                    avs_byteenable_in,
   input  wire logic [IPR_DATA_W-1:0]                  avs_writedata_in,
   input  wire logic [IPR_NUM_SRC-1:0]                 src_flag_in,
   output logic                                        avs_waitrequest_out,
   output logic [IPR_DATA_W-1:0]                       avs_readdata_out,
   output logic [1:0]                                  avs_response_out,
   output ipr_src_field_t [IPR_NUM_SRC-1:0]            src_field_out,
   output logic [IPR_NUM_SRC-1:0]                      src_enabled_out,
   output logic [IPR_NUM_SRC-1:0]                      src_request_out
);

   // bundled bus request; the master holds it steady until answered
   ipr_avl_req_t req;

   // handshake strobes from the bus slave
   logic capture;
   logic commit;

   // address decode
   logic hit_ctl4;
   logic hit_ctl5;
   logic hit_stat;
   logic hit_any;

   // write strobes
   logic wr_commit;
   logic [IPR_NUM_SRC-1:0] src_we;

   // per-source stored fields
   ipr_src_field_t [IPR_NUM_SRC-1:0] field;
   logic [IPR_NUM_SRC-1:0]           enabled;

   // readback words
   logic [IPR_DATA_W-1:0] ctl4_word;
   logic [IPR_DATA_W-1:0] ctl5_word;
   logic [IPR_DATA_W-1:0] stat_word;
   logic [IPR_DATA_W-1:0] rd_mux;

   // registered outputs
   logic [IPR_DATA_W-1:0]  readdata_reg;
   logic [1:0]             response_reg;
   logic [IPR_NUM_SRC-1:0] enabled_reg;
   logic [IPR_NUM_SRC-1:0] request_reg;
   ipr_src_field_t [IPR_NUM_SRC-1:0] field_out_reg;

   // diagnostic: software wrote a one into a reserved bit
   logic rsvd_seen_reg;
   logic rsvd_set;
   logic rsvd_clr;

   // pack the bus signals
   assign req.read  = avs_read_in;
   assign req.write = avs_write_in;
   assign req.addr  = avs_address_in;
   assign req.be    = avs_byteenable_in;
   assign req.wdata = avs_writedata_in;

   // handshake: one wait cycle, then one answer cycle
   ipr_bus_slave u_bus (
      .ref_clk_in      (ref_clk_in),
      .nrst_in         (nrst_in),
      .read_in         (req.read),
      .write_in        (req.write),
      .waitrequest_out (avs_waitrequest_out),
      .capture_out     (capture),
      .commit_out      (commit)
   );

   // word-aligned decode; low address bits are ignored for 32-bit words
   assign hit_ctl4 = (req.addr[IPR_ADDR_W-1:2] == IPR_OFS_CTL4[IPR_ADDR_W-1:2]);
   assign hit_ctl5 = (req.addr[IPR_ADDR_W-1:2] == IPR_OFS_CTL5[IPR_ADDR_W-1:2]);
   assign hit_stat = (req.addr[IPR_ADDR_W-1:2] == IPR_OFS_STAT[IPR_ADDR_W-1:2]);
   assign hit_any  = hit_ctl4 || hit_ctl5 || hit_stat;

   // writes take effect only on the edge where waitrequest is seen low
   assign wr_commit = commit && req.write;

   // one field register per source, steered by its register and byte lane
   genvar s;
   generate
      for (s = 0; s < IPR_NUM_SRC; s++) begin : g_src
         localparam int LANE = int'(IPR_SRC_LANE[2*s +: 2]);
         logic reg_hit;

         // ctl_4 sources sit in lanes 1 and 0, ctl_5 sources in all four lanes
         assign reg_hit   = IPR_SRC_IN_CTL5[s] ? hit_ctl5 : hit_ctl4;
         assign src_we[s] = wr_commit && reg_hit && req.be[LANE];

         ipr_field_reg u_field (
            .ref_clk_in (ref_clk_in),
            .nrst_in    (nrst_in),
            .write_in   (src_we[s]),
            .lane_in    (req.wdata[LANE*IPR_LANE_W +: IPR_LANE_W]),
            .field_out  (field[s])
         );

         // priority code zero means the source is switched off
         assign enabled[s] = (field[s].prio != IPR_PRIO_OFF);
      end
   endgenerate

   // place each source's fields back at its lane; reserved bits read zero
   always_comb begin
      ctl4_word = '0;
      ctl5_word = '0;
      for (int i = 0; i < IPR_NUM_SRC; i++) begin
         if (IPR_SRC_IN_CTL5[i]) begin
            ctl5_word[int'(IPR_SRC_LANE[2*i +: 2])*IPR_LANE_W + IPR_PRIO_LSB +: IPR_PRIO_W]
               = field[i].prio;
            ctl5_word[int'(IPR_SRC_LANE[2*i +: 2])*IPR_LANE_W + IPR_SUB_LSB +: IPR_SUB_W]
               = field[i].sub;
         end else begin
            ctl4_word[int'(IPR_SRC_LANE[2*i +: 2])*IPR_LANE_W + IPR_PRIO_LSB +: IPR_PRIO_W]
               = field[i].prio;
            ctl4_word[int'(IPR_SRC_LANE[2*i +: 2])*IPR_LANE_W + IPR_SUB_LSB +: IPR_SUB_W]
               = field[i].sub;
         end
      end
   end

   // status word shows enables, gated requests and the reserved-write flag
   always_comb begin
      stat_word = '0;
      stat_word[IPR_STAT_EN_LSB +: IPR_NUM_SRC]   = enabled_reg;
      stat_word[IPR_STAT_PEND_LSB +: IPR_NUM_SRC] = request_reg;
      stat_word[IPR_STAT_RSVD_BIT]                = rsvd_seen_reg;
   end

   // read mux; unmapped words read zero
   always_comb begin
      if (hit_ctl4) begin
         rd_mux = ctl4_word;
      end else if (hit_ctl5) begin
         rd_mux = ctl5_word;
      end else if (hit_stat) begin
         rd_mux = stat_word;
      end else begin
         rd_mux = '0;
      end
   end

   // read data and response are latched at capture and stand in the answer cycle
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         readdata_reg <= '0;
      end else if (capture) begin
         readdata_reg <= req.read ? rd_mux : '0;
      end
   end

   // unmapped addresses answer with a slave error, reads and writes alike
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         response_reg <= IPR_RESP_OKAY;
      end else if (capture) begin
         response_reg <= hit_any ? IPR_RESP_OKAY : IPR_RESP_SLVERR;
      end
   end

   // a reserved bit written as one is tolerated but remembered
   always_comb begin
      rsvd_set = 1'b0;
      for (int i = 0; i < IPR_NUM_SRC; i++) begin
         if (src_we[i] &&
             ((req.wdata[int'(IPR_SRC_LANE[2*i +: 2])*IPR_LANE_W +: IPR_LANE_W]
               & IPR_RSVD_MASK) != '0)) begin
            rsvd_set = 1'b1;
         end
      end
   end

   // write one to clear; a new offence in the same cycle wins
   assign rsvd_clr = wr_commit && hit_stat && req.be[IPR_STAT_RSVD_BE] &&
                     req.wdata[IPR_STAT_RSVD_BIT];

   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rsvd_seen_reg <= 1'b0;
      end else if (rsvd_set) begin
         rsvd_seen_reg <= 1'b1;
      end else if (rsvd_clr) begin
         rsvd_seen_reg <= 1'b0;
      end
   end

   // fields to the arbiter, one cycle after the stored value changes
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         field_out_reg <= '0;
      end else begin
         field_out_reg <= field;
      end
   end

   // enable flags follow the priority fields
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         enabled_reg <= '0;
      end else begin
         enabled_reg <= enabled;
      end
   end

   // flags of disabled sources never reach the arbiter
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         request_reg <= '0;
      end else begin
         request_reg <= src_flag_in & enabled;
      end
   end

   assign avs_readdata_out = readdata_reg;
   assign avs_response_out = response_reg;
   assign src_field_out    = field_out_reg;
   assign src_enabled_out  = enabled_reg;
   assign src_request_out  = request_reg;

endmodule

// ==== ipr_prio_bank_asserts.sv ====
// concurrent checks on the priority register bank ports
`timescale 1ns/10ps
module ipr_prio_bank_asserts
   import ipr_pkg::*;
(
   input  wire logic                            ref_clk_in,
   input  wire logic                            nrst_in,
   input  wire logic [IPR_ADDR_W-1:0]           avs_address_in,
   input  wire logic                            avs_read_in,
   input  wire logic                            avs_write_in,
   input  wire logic [IPR_BE_W-1:0]             avs_byteenable_in,
   input  wire logic [IPR_DATA_W-1:0]           avs_writedata_in,
   input  wire logic [IPR_NUM_SRC-1:0]          src_flag_in,
   input  wire logic                            avs_waitrequest_out,
   input  wire logic [IPR_DATA_W-1:0]           avs_readdata_out,
   input  wire logic [1:0]                      avs_response_out,
   input  wire ipr_src_field_t [IPR_NUM_SRC-1:0] src_field_out,
   input  wire logic [IPR_NUM_SRC-1:0]          src_enabled_out,
   input  wire logic [IPR_NUM_SRC-1:0]          src_request_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!nrst_in);
   logic [IPR_NUM_SRC-1:0] prio_nz;
   logic                   done_w;
   // zero priority code is the off state
   always_comb begin
      for (int i = 0; i < IPR_NUM_SRC; i++) begin
         prio_nz[i] = (src_field_out[i].prio != IPR_PRIO_OFF);
      end
   end
   // a write commits only at the edge that sees waitrequest low
   assign done_w = avs_write_in && !avs_waitrequest_out;
   chk_ack_one: assert property ($fell(avs_waitrequest_out) |=> avs_waitrequest_out)
      else $error("waitrequest low for more than one cycle");
   chk_ack_bound: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
      |-> ##[1:2] !avs_waitrequest_out) else $error("transfer not answered in time");
   chk_enable_map: assert property (src_enabled_out == prio_nz)
      else $error("enable does not follow priority code");
   chk_req_flag: assert property ((src_request_out & ~$past(src_flag_in)) == '0)
      else $error("request without a flag");
   // a disabled source must never pass its flag on
   chk_req_gated: assert property (src_request_out ==
      ($past(src_flag_in) & src_enabled_out)) else $error("request not gated by enable");
   chk_reset_clear: assert property ($rose(nrst_in) |-> src_field_out == '0
      && src_enabled_out == '0 && avs_waitrequest_out) else $error("bad state after reset");
   chk_capt4_field: assert property (done_w && avs_address_in == IPR_OFS_CTL4
      && avs_byteenable_in[1] |-> ##2
      src_field_out[IPR_SRC_CAPT4] == $past(avs_writedata_in[12:8], 2))
      else $error("capture4 field mismatch");
   chk_timer4_field: assert property (done_w && avs_address_in == IPR_OFS_CTL4
      && avs_byteenable_in[0] |-> ##2
      src_field_out[IPR_SRC_TIMER4] == $past(avs_writedata_in[4:0], 2))
      else $error("timer4 field mismatch");
   chk_serial_field: assert property (done_w && avs_address_in == IPR_OFS_CTL5
      && avs_byteenable_in[3] |-> ##2
      src_field_out[IPR_SRC_SERIAL1] == $past(avs_writedata_in[28:24], 2))
      else $error("serial1 field mismatch");
   chk_ctl5_rsvd: assert property (!avs_waitrequest_out && avs_read_in
      && avs_address_in == IPR_OFS_CTL5 |-> (avs_readdata_out & 32'he0e0e0e0) == '0)
      else $error("reserved bits read nonzero");
   chk_unmapped_err: assert property (!avs_waitrequest_out && avs_address_in[3:2] == 2'h3
      |-> avs_response_out == IPR_RESP_SLVERR) else $error("unmapped access not flagged");
   cov_serial_wr: cover property (done_w && avs_address_in == IPR_OFS_CTL5);
   cov_unmapped: cover property (!avs_waitrequest_out && avs_address_in[3:2] == 2'h3);
   cov_request: cover property (src_request_out != '0);
endmodule

bind ipr_prio_bank ipr_prio_bank_asserts chk_u (.ref_clk_in, .nrst_in, .avs_address_in,
   .avs_read_in, .avs_write_in, .avs_byteenable_in, .avs_writedata_in, .src_flag_in,
   .avs_waitrequest_out, .avs_readdata_out, .avs_response_out, .src_field_out,
   .src_enabled_out, .src_request_out);

// ==== ipr_prio_bank_tb.sv ====
// self-checking bench for the priority register bank
`timescale 1ns/10ps
module ipr_prio_bank_tb
   import ipr_pkg::*;
;
   typedef struct packed {
      logic [IPR_ADDR_W-1:0] addr;
      logic [IPR_BE_W-1:0]   be;
      logic [IPR_DATA_W-1:0] wdata;
      logic [IPR_DATA_W-1:0] rdata;
      logic [1:0]            resp;
   } ipr_row_t;
   logic                                ref_clk_in = 1'b0;
   logic                                nrst_in = 1'b0;
   ipr_avl_req_t                        req = '0;
   logic [IPR_NUM_SRC-1:0]              flag = '0;
   logic                                wait_out;
   logic [31:0]                         rd_out;
   logic [31:0]                         rd;
   logic [31:0]                         c4_m = '0;
   logic [31:0]                         c5_m = '0;
   logic [1:0]                          resp_out;
   logic [1:0]                          rs;
   ipr_src_field_t [IPR_NUM_SRC-1:0]    fld;
   logic [IPR_NUM_SRC-1:0]              en_out;
   logic [IPR_NUM_SRC-1:0]              req_out;
   int                                  err_count = 0;
   int                                  n_tests = 0;
   // register writes and their readback; the last row hits the unmapped word
   ipr_row_t rows [7] = '{
      '{IPR_OFS_CTL4, 4'hf, 32'hffffffff, 32'h00001f1f, IPR_RESP_OKAY},
      '{IPR_OFS_CTL5, 4'hf, 32'hffffffff, 32'h1f1f1f1f, IPR_RESP_OKAY},
      '{IPR_OFS_CTL4, 4'h3, 32'h00001234, 32'h00001214, IPR_RESP_OKAY},
      '{IPR_OFS_CTL5, 4'h4, 32'h00aa0000, 32'h1f0a1f1f, IPR_RESP_OKAY},
      '{IPR_OFS_CTL5, 4'h8, 32'h5b000000, 32'h1b0a1f1f, IPR_RESP_OKAY},
      '{IPR_OFS_CTL4, 4'hc, 32'hffff0000, 32'h00001214, IPR_RESP_OKAY},
      '{4'hc,         4'hf, 32'hffffffff, 32'h00000000, IPR_RESP_SLVERR}};

   ipr_prio_bank dut_u (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
      .avs_address_in(req.addr), .avs_read_in(req.read), .avs_write_in(req.write),
      .avs_byteenable_in(req.be), .avs_writedata_in(req.wdata), .src_flag_in(flag),
      .avs_waitrequest_out(wait_out), .avs_readdata_out(rd_out), .avs_response_out(resp_out),
      .src_field_out(fld), .src_enabled_out(en_out), .src_request_out(req_out));

   // 100 MHz clock
   always #5 ref_clk_in = ~ref_clk_in;

   task automatic conclude();
      if (err_count == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // one bus transfer, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [3:0] a, input logic [3:0] be,
                      input logic [31:0] d, output logic [31:0] q, output logic [1:0] r);
      @(posedge ref_clk_in);
      req <= '{read: !wr, write: wr, addr: a, be: be, wdata: d};
      // no local limit: a hung slave is left to the watchdog
      do begin
         @(posedge ref_clk_in);
      end while (wait_out !== 1'b0);
      q = rd_out;
      r = resp_out;
      req <= '0;
   endtask

   // field outputs trail the stored value, so give them time to land
   task automatic settle();
      repeat (3) @(posedge ref_clk_in);
      #1;
   endtask

   // expected field vector built from the two register images
   function automatic logic [29:0] fexp(input logic [31:0] a, input logic [31:0] b);
      return {b[28:24], b[20:16], b[12:8], b[4:0], a[12:8], a[4:0]};
   endfunction

   // main sequence
   initial begin
      repeat (4) @(posedge ref_clk_in);
      nrst_in <= 1'b1;
      foreach (rows[i]) begin
         bus(1'b1, rows[i].addr, rows[i].be, rows[i].wdata, rd, rs);
         check("write resp", {30'h0, rs}, {30'h0, rows[i].resp});
         bus(1'b0, rows[i].addr, 4'h0, 32'h0, rd, rs);
         check("readback", rd, rows[i].rdata);
         check("read resp", {30'h0, rs}, {30'h0, rows[i].resp});
         if (rows[i].addr == IPR_OFS_CTL4) c4_m = rows[i].rdata;
         if (rows[i].addr == IPR_OFS_CTL5) c5_m = rows[i].rdata;
         settle();
         check("fields", {2'h0, fld}, {2'h0, fexp(c4_m, c5_m)});
      end
      // every priority code, all flags raised; reserved bits kept zero
      @(posedge ref_clk_in);
      flag <= 6'h3f;
      for (int c = 0; c < 8; c++) begin
         bus(1'b1, IPR_OFS_CTL4, 4'h2, {16'h0, 3'h0, c[2:0], c[1:0], 8'h0}, rd, rs);
         bus(1'b1, IPR_OFS_CTL5, 4'h8, {3'h0, ~c[2:0], c[1:0], 24'h0}, rd, rs);
         settle();
         check("capture4", {27'h0, fld[1]}, {27'h0, c[2:0], c[1:0]});
         check("capture4 req", {31'h0, req_out[1]}, {31'h0, c != 0});
         check("serial1", {27'h0, fld[5]}, {27'h0, ~c[2:0], c[1:0]});
         check("serial1 req", {31'h0, req_out[5]}, {31'h0, c != 7});
         check("enables", {26'h0, en_out}, {26'h0, c != 7, 3'h7, c != 0, 1'b1});
      end
      // status: serial1 now off, sticky reserved-write flag set, then cleared
      bus(1'b0, IPR_OFS_STAT, 4'h0, 32'h0, rd, rs);
      check("status", rd, 32'h00011f1f);
      bus(1'b1, IPR_OFS_STAT, 4'h4, 32'h3f01003f, rd, rs);
      bus(1'b0, IPR_OFS_STAT, 4'h0, 32'h0, rd, rs);
      check("status clr", rd, 32'h00001f1f);
      // reset in mid-run with flags still high
      @(posedge ref_clk_in);
      nrst_in <= 1'b0;
      repeat (4) @(posedge ref_clk_in);
      nrst_in <= 1'b1;
      settle();
      check("rst fields", {2'h0, fld}, 32'h0);
      check("rst req", {26'h0, req_out}, 32'h0);
      check("rst enables", {26'h0, en_out}, 32'h0);
      bus(1'b0, IPR_OFS_CTL5, 4'h0, 32'h0, rd, rs);
      check("rst ctl5", rd, 32'h0);
      conclude();
   end

   // watchdog, far beyond the well under two hundred cycles the sequence needs
   initial begin
      #100000;
      err_count++;
      conclude();
   end
endmodule
